// [core/css_pkg.sv]
// package: constants, codes and decode helper for the clock start-up block
package css_pkg;

  // counter width, wide enough for the long watchdog delay
  localparam int CNT_W = 17;

  // fuse polarity: a programmed fuse reads as zero
  localparam logic FUSE_PROG = 1'b0;

  // delivered fuse image: internal rc 1 mhz, longest start-up
  localparam logic [3:0] CLOCK_SOURCE_SELECT_DEF = 4'h1;
  localparam logic [1:0] SUT_DEF   = 2'h2;
  localparam logic       AMP_DEF   = 1'b1;

  // source classes from the 4-bit source select field
  localparam logic [2:0] CLS_XTAL = 3'h1;
  localparam logic [2:0] CLS_LFXT = 3'h2;
  localparam logic [2:0] CLS_XRC  = 3'h3;
  localparam logic [2:0] CLS_IRC  = 3'h4;
  localparam logic [2:0] CLS_XCLK = 3'h5;

  // source select boundaries
  localparam logic [3:0] SEL_XTAL_MIN = 4'ha;
  localparam logic [3:0] SEL_LFXT     = 4'h9;
  localparam logic [3:0] SEL_XRC_MIN  = 4'h5;
  localparam logic [3:0] SEL_IRC_MIN  = 4'h1;

  // crystal range codes (upper three select bits)
  localparam logic [2:0] XR_LOW  = 3'h5;
  localparam logic [2:0] XR_MID  = 3'h6;
  localparam logic [2:0] XR_HIGH = 3'h7;

  // reported frequency range
  localparam logic [2:0] RNG_NONE = 3'h0;
  localparam logic [2:0] RNG_LOW  = 3'h1;
  localparam logic [2:0] RNG_MID  = 3'h2;
  localparam logic [2:0] RNG_HIGH = 3'h3;
  localparam logic [2:0] RNG_WIDE = 3'h4;

  // reset delay choice
  localparam logic [1:0] DLY_NONE  = 2'h0;
  localparam logic [1:0] DLY_SHORT = 2'h1;
  localparam logic [1:0] DLY_LONG  = 2'h2;

  // start-up counts in source clock cycles
  localparam logic [16:0] CYC_6   = 17'h00006;
  localparam logic [16:0] CYC_18  = 17'h00012;
  localparam logic [16:0] CYC_258 = 17'h00102;
  localparam logic [16:0] CYC_1K  = 17'h00400;
  localparam int          CYC_16K = 16384;
  localparam int          CYC_32K = 32768;

  // reset delay counts in watchdog oscillator cycles
  localparam logic [16:0] WDT_SHORT = 17'h01000;
  localparam int          WDT_LONG  = 65536;

  // register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_FUSE   = 8'h02;
  localparam logic [7:0] ADDR_DECODE = 8'h03;

  // control register bits
  localparam int CTRL_HALT  = 0;
  localparam int CTRL_CONV  = 1;
  localparam int CTRL_SLEEP = 2;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_BOOT  = 4'b0001,
    ST_RUN   = 4'b0010,
    ST_SLEEP = 4'b0100,
    ST_WAKE  = 4'b1000
  } css_state_t;

  // source class from the select field
  function automatic logic [2:0] css_decode_class(input logic [3:0] sel);
    logic [2:0] cls;
    if (sel >= SEL_XTAL_MIN) cls = CLS_XTAL;
    else if (sel == SEL_LFXT) cls = CLS_LFXT;
    else if (sel >= SEL_XRC_MIN) cls = CLS_XRC;
    else if (sel >= SEL_IRC_MIN) cls = CLS_IRC;
    else cls = CLS_XCLK;
    return cls;
  endfunction

endpackage

// [core/css_startup_counter.sv]
// file: restartable tick counter with a terminal-count done flag
`timescale 1ns/10ps
`default_nettype none
module css_startup_counter (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  // control
  input  wire logic        restart_in,
  input  wire logic        tick_in,
  input  wire logic [16:0] target_in,
  // status
  output logic             done_out
);

  logic [16:0] cnt_r; // ticks seen since restart

  // count ticks until the target, then hold done
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || restart_in) begin
      cnt_r    <= 17'h00000;
      done_out <= 1'b0;
    end else if (!done_out) begin
      if (cnt_r == target_in) begin
        done_out <= 1'b1;
      end else if (tick_in) begin
        cnt_r <= cnt_r + 17'h00001;
      end
    end
  end

  AST_CNT_DONE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    $rose(done_out) |-> $past(cnt_r) == $past(target_in))
    else $error("done rose before terminal count");

  AST_CNT_RESTART: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    restart_in |=> !done_out && cnt_r == 17'h00000)
    else $error("restart did not clear the counter");

endmodule // css_startup_counter
`default_nettype wire

// [core/css_source_decode.sv]
// file: fuse decode into source class, range, wake count and reset delay
`timescale 1ns/10ps
`default_nettype none
module css_source_decode #(
  parameter logic [16:0] CYC_16K_P = 17'h04000,
  parameter logic [16:0] CYC_32K_P = 17'h08000
) (
  // fuse image
  input  wire logic [3:0]  clock_source_select_in,
  input  wire logic [1:0]  sut_in,
  input  wire logic        amp_in,
  // decoded result
  output logic [2:0]       class_out,
  output logic [2:0]       range_out,
  output logic [16:0]      wake_cyc_out,
  output logic [1:0]       dly_sel_out
);

  // per-class start-up table lookup
  always_comb begin
    class_out    = css_pkg::css_decode_class(clock_source_select_in);
    range_out    = css_pkg::RNG_NONE;
    wake_cyc_out = css_pkg::CYC_6;
    dly_sel_out  = css_pkg::DLY_LONG;
    case (class_out)
      css_pkg::CLS_XTAL: begin
        // programmed amplifier option widens every range code
        if (amp_in == css_pkg::FUSE_PROG) range_out = css_pkg::RNG_WIDE;
        else if (clock_source_select_in[3:1] == css_pkg::XR_LOW) range_out = css_pkg::RNG_LOW;
        else if (clock_source_select_in[3:1] == css_pkg::XR_MID) range_out = css_pkg::RNG_MID;
        else range_out = css_pkg::RNG_HIGH;
        case ({clock_source_select_in[0], sut_in})
          3'h0: begin wake_cyc_out = css_pkg::CYC_258; dly_sel_out = css_pkg::DLY_SHORT; end
          3'h1: begin wake_cyc_out = css_pkg::CYC_258; dly_sel_out = css_pkg::DLY_LONG;  end
          3'h2: begin wake_cyc_out = css_pkg::CYC_1K;  dly_sel_out = css_pkg::DLY_NONE;  end
          3'h3: begin wake_cyc_out = css_pkg::CYC_1K;  dly_sel_out = css_pkg::DLY_SHORT; end
          3'h4: begin wake_cyc_out = css_pkg::CYC_1K;  dly_sel_out = css_pkg::DLY_LONG;  end
          3'h5: begin wake_cyc_out = CYC_16K_P;        dly_sel_out = css_pkg::DLY_NONE;  end
          3'h6: begin wake_cyc_out = CYC_16K_P;        dly_sel_out = css_pkg::DLY_SHORT; end
          default: begin wake_cyc_out = CYC_16K_P;     dly_sel_out = css_pkg::DLY_LONG;  end
        endcase
      end
      css_pkg::CLS_LFXT: begin
        // reserved code falls back to the safest setting
        wake_cyc_out = (sut_in[1]) ? CYC_32K_P : css_pkg::CYC_1K;
        dly_sel_out  = (sut_in == 2'h0) ? css_pkg::DLY_SHORT : css_pkg::DLY_LONG;
      end
      css_pkg::CLS_XRC: begin
        wake_cyc_out = (sut_in == 2'h3) ? css_pkg::CYC_6 : css_pkg::CYC_18;
        if (sut_in == 2'h0) dly_sel_out = css_pkg::DLY_NONE;
        else if (sut_in == 2'h2) dly_sel_out = css_pkg::DLY_LONG;
        else dly_sel_out = css_pkg::DLY_SHORT;
      end
      default: begin
        // internal rc and external clock share the 6-cycle start
        if (sut_in == 2'h0) dly_sel_out = css_pkg::DLY_NONE;
        else if (sut_in == 2'h1) dly_sel_out = css_pkg::DLY_SHORT;
        else dly_sel_out = css_pkg::DLY_LONG;
      end
    endcase
  end

endmodule // css_source_decode
`default_nettype wire

// [core/css_clock_startup.sv]
// file: top of the clock source select and start-up sequencer
`timescale 1ns/10ps
`default_nettype none
//
// Function
// - decode source select into five source classes
// - fuse value one unprogrammed, zero programmed
// - wake from deep sleep counts source cycles
// - reset adds none, 4096 or 65536 watchdog cycles
// - default fuses select 0001 and 10
// - amplifier option programmed gives full swing
// - upper select bits pick crystal frequency range, wide range when amplifier option programmed
// - crystal group zero start-up code mapping
// - crystal group one start-up code mapping
// - async timer clock keeps running in sleep
// - converter clock runs while core halted
// - core clock gate stops all core logic
module css_clock_startup #(
  // long counts, shortened for simulation
  parameter logic [16:0] WDT_LONG_CYC = 17'(css_pkg::WDT_LONG),
  parameter logic [16:0] XTAL_16K_CYC = 17'(css_pkg::CYC_16K),
  parameter logic [16:0] LFXT_32K_CYC = 17'(css_pkg::CYC_32K)
) (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       srst_in,
  // fuse image
  input  wire logic [3:0] clock_source_select_field_in,
  input  wire logic [1:0] startup_time_field_in,
  input  wire logic       oscillator_amplifier_option_in,
  input  wire logic       fuse_valid_in,
  // clock ticks, one-cycle enables
  input  wire logic       source_clock_tick_in,
  input  wire logic       watchdog_oscillator_tick_in,
  input  wire logic       async_timer_clock_tick_in,
  input  wire logic       converter_clock_tick_in,
  // wake event
  input  wire logic       wake_in,
  // register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic [7:0]      reg_rdata_out,
  // clock gates and ticks
  output logic            core_clock_en_out,
  output logic            io_clock_en_out,
  output logic            converter_clock_tick_out,
  output logic            async_timer_clock_tick_out,
  // decoded configuration
  output logic            amp_full_swing_out,
  output logic [2:0]      source_class_out,
  output logic [2:0]      crystal_range_out,
  // sequencer status
  output logic            startup_busy_out,
  output logic            power_down_out
);

  // fuse shadow, loaded once after reset release
  logic [3:0] clock_source_select_r;  // clock source select field
  logic [1:0] sut_r;    // start-up time field
  logic       amp_r;    // amplifier option fuse
  logic       cap_pend_r; // capture still pending

  // control register
  logic halt_r;     // software gate of the core clock
  logic conv_en_r;  // converter clock enable

  // sequencer
  css_pkg::css_state_t state_r;   // current state
  css_pkg::css_state_t state_nxt; // next state
  logic wake_restart_r;           // restart pulse on wake

  // decode results
  logic [2:0]  dec_class;   // source class
  logic [2:0]  dec_range;   // frequency range
  logic [16:0] dec_wake;    // source cycles to count
  logic [1:0]  dec_dly;     // reset delay choice
  logic [16:0] wdt_target;  // watchdog cycles to count

  // counter handshakes
  logic src_restart; // source counter restart
  logic src_done;    // source count complete
  logic wdt_done;    // watchdog count complete

  // bus decode
  logic sleep_cmd;   // software sleep request
  logic ctrl_wr;     // write hits control

  // fuse capture: reset loads the delivered defaults
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      clock_source_select_r    <= css_pkg::CLOCK_SOURCE_SELECT_DEF;
      sut_r      <= css_pkg::SUT_DEF;
      amp_r      <= css_pkg::AMP_DEF;
      cap_pend_r <= 1'b1;
    end else if (cap_pend_r) begin
      // an absent fuse image keeps the defaults
      if (fuse_valid_in) begin
        clock_source_select_r <= clock_source_select_field_in;
        sut_r   <= startup_time_field_in;
        amp_r   <= oscillator_amplifier_option_in;
      end
      cap_pend_r <= 1'b0;
    end
  end

  // table lookup for the captured fuses
  css_source_decode #(
    .CYC_16K_P (XTAL_16K_CYC),
    .CYC_32K_P (LFXT_32K_CYC)
  ) u_decode (
    .clock_source_select_in     (clock_source_select_r),
    .sut_in       (sut_r),
    .amp_in       (amp_r),
    .class_out    (dec_class),
    .range_out    (dec_range),
    .wake_cyc_out (dec_wake),
    .dly_sel_out  (dec_dly)
  );

  // watchdog delay length from the delay choice
  always_comb begin
    if (dec_dly == css_pkg::DLY_LONG) begin
      wdt_target = WDT_LONG_CYC;
    end else if (dec_dly == css_pkg::DLY_SHORT) begin
      wdt_target = css_pkg::WDT_SHORT;
    end else begin
      wdt_target = 17'h00000;
    end
  end

  // source counter restarts at boot and on every wake
  assign src_restart = cap_pend_r | wake_restart_r;

  // oscillator cycles, on the selected source
  css_startup_counter u_src_cnt (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .restart_in (src_restart),
    .tick_in    (source_clock_tick_in),
    .target_in  (dec_wake),
    .done_out   (src_done)
  );

  // real-time part, only after reset
  css_startup_counter u_wdt_cnt (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .restart_in (cap_pend_r),
    .tick_in    (watchdog_oscillator_tick_in),
    .target_in  (wdt_target),
    .done_out   (wdt_done)
  );

  // register port decode
  assign ctrl_wr   = reg_wr_in && (reg_addr_in == css_pkg::ADDR_CTRL);
  assign sleep_cmd = ctrl_wr && reg_wdata_in[css_pkg::CTRL_SLEEP];

  // control register; the sleep bit is a command, not stored
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      halt_r    <= 1'b0;
      conv_en_r <= 1'b0;
    end else if (ctrl_wr) begin
      halt_r    <= reg_wdata_in[css_pkg::CTRL_HALT];
      conv_en_r <= reg_wdata_in[css_pkg::CTRL_CONV];
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      css_pkg::ST_BOOT: begin
        // both delays must be over before the core runs
        if (!cap_pend_r && src_done && wdt_done) begin
          state_nxt = css_pkg::ST_RUN;
        end
      end
      css_pkg::ST_RUN: begin
        if (sleep_cmd) begin
          state_nxt = css_pkg::ST_SLEEP;
        end
      end
      css_pkg::ST_SLEEP: begin
        if (wake_in) begin
          state_nxt = css_pkg::ST_WAKE;
        end
      end
      css_pkg::ST_WAKE: begin
        // first wake cycle still sees the stale done flag
        if (!wake_restart_r && src_done) begin
          state_nxt = css_pkg::ST_RUN;
        end
      end
      default: begin
        state_nxt = css_pkg::ST_BOOT;
      end
    endcase
  end

  // sequencer state register
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_r <= css_pkg::ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // wake restart pulse, one cycle on entry to wake
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      wake_restart_r <= 1'b0;
    end else begin
      wake_restart_r <= (state_r == css_pkg::ST_SLEEP) && wake_in;
    end
  end

  // clock gates, taken from the next state so release is not late
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      core_clock_en_out <= 1'b0;
      io_clock_en_out   <= 1'b0;
      startup_busy_out  <= 1'b1;
      power_down_out    <= 1'b0;
    end else begin
      // a held core clock freezes register file and stack
      core_clock_en_out <= (state_nxt == css_pkg::ST_RUN) && !halt_r;
      io_clock_en_out   <= (state_nxt == css_pkg::ST_RUN);
      startup_busy_out  <= (state_nxt == css_pkg::ST_BOOT) ||
                           (state_nxt == css_pkg::ST_WAKE);
      power_down_out    <= (state_nxt == css_pkg::ST_SLEEP);
    end
  end

  // dedicated domain ticks
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      async_timer_clock_tick_out <= 1'b0;
      converter_clock_tick_out   <= 1'b0;
    end else begin
      // async timer ignores sleep: real-time counting
      async_timer_clock_tick_out <= async_timer_clock_tick_in;
      // converter ignores the core gate, quieter conversions
      converter_clock_tick_out   <= converter_clock_tick_in && conv_en_r &&
                                    (state_r != css_pkg::ST_BOOT);
    end
  end

  // decoded configuration outputs
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      amp_full_swing_out <= 1'b0;
      source_class_out   <= css_pkg::CLS_IRC;
      crystal_range_out  <= css_pkg::RNG_NONE;
    end else begin
      // programmed fuse reads zero
      amp_full_swing_out <= (amp_r == css_pkg::FUSE_PROG);
      source_class_out   <= dec_class;
      crystal_range_out  <= dec_range;
    end
  end

  // read data, valid in the cycle after the strobe
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (reg_addr_in == css_pkg::ADDR_CTRL) begin
        reg_rdata_out <= {6'h00, conv_en_r, halt_r};
      end else if (reg_addr_in == css_pkg::ADDR_STATUS) begin
        reg_rdata_out <= {src_done, wdt_done, 2'h0, state_r};
      end else if (reg_addr_in == css_pkg::ADDR_FUSE) begin
        reg_rdata_out <= {1'b0, amp_r, sut_r, clock_source_select_r};
      end else if (reg_addr_in == css_pkg::ADDR_DECODE) begin
        reg_rdata_out <= {dec_dly, dec_range, dec_class};
      end else begin
        // unmapped reads return zero
        reg_rdata_out <= 8'h00;
      end
    end
  end

  // checks on the sequencer and decode
  AST_DECODE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    !cap_pend_r |=> source_class_out == css_pkg::css_decode_class($past(clock_source_select_r)))
    else $error("source class does not follow select field");

  AST_AMP_POLARITY: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    amp_r == 1'b1 |=> !amp_full_swing_out)
    else $error("unprogrammed amplifier fuse gave full swing");

  AST_AMP_FULL: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    amp_r == 1'b0 |=> amp_full_swing_out)
    else $error("programmed amplifier fuse gave reduced swing");

  AST_DEFAULT: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    $fell(srst_in) |-> clock_source_select_r == css_pkg::CLOCK_SOURCE_SELECT_DEF && sut_r == css_pkg::SUT_DEF)
    else $error("reset did not load default fuses");

  AST_RANGE_LOW: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    dec_class == css_pkg::CLS_XTAL && amp_r && clock_source_select_r[3:1] == css_pkg::XR_LOW
    |=> crystal_range_out == css_pkg::RNG_LOW)
    else $error("crystal low range misdecoded");

  AST_XTAL_G0: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    dec_class == css_pkg::CLS_XTAL && !clock_source_select_r[0] && sut_r == 2'h0
    |-> dec_wake == css_pkg::CYC_258 && wdt_target == css_pkg::WDT_SHORT)
    else $error("crystal group zero code 00 misdecoded");

  AST_XTAL_G1: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    dec_class == css_pkg::CLS_XTAL && clock_source_select_r[0] && sut_r == 2'h3
    |-> dec_wake == XTAL_16K_CYC && wdt_target == WDT_LONG_CYC)
    else $error("crystal group one code 11 misdecoded");

  AST_BOOT_HOLD: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    state_r == css_pkg::ST_BOOT && !wdt_done |=> !core_clock_en_out)
    else $error("core released before watchdog delay");

  AST_RELEASE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    state_r == css_pkg::ST_BOOT && !cap_pend_r && src_done && wdt_done && !halt_r
    |=> core_clock_en_out && state_r == css_pkg::ST_RUN)
    else $error("core not released when both delays ended");

  AST_WAKE_HOLD: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    state_r == css_pkg::ST_SLEEP && wake_in |=> !core_clock_en_out [*2])
    else $error("core ran before wake count");

  AST_GATE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    halt_r |=> !core_clock_en_out)
    else $error("core clock ran while halted");

  AST_ASYNC: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    state_r == css_pkg::ST_SLEEP && async_timer_clock_tick_in |=> async_timer_clock_tick_out)
    else $error("async timer stopped in sleep");

  AST_CONV: assert property (@(posedge clk_sys_in) disable iff (srst_in)
    halt_r && conv_en_r && state_r == css_pkg::ST_RUN && converter_clock_tick_in
    |=> converter_clock_tick_out)
    else $error("converter stopped with core halted");

endmodule // css_clock_startup
`default_nettype wire

// [dv/css_osc_model.sv]
// partner model: crystal or resonator and watchdog oscillator as tick pulses
`timescale 1ns/10ps
`default_nettype none
module css_osc_model (
  // clock
  input  wire logic clk_sys_in,
  // control
  input  wire logic slow_in,
  // ticks
  output logic      src_tick_out,
  output logic      wdt_tick_out
);
  // toggle for the slow rate; starts low so the first slow tick is known
  logic ph_r = 1'b0;
  // one tick per cycle, or every other cycle when slow
  // the bench steps range codes 101 to 111 through 258, 1024 and 16k-cycle starts
  always_ff @(posedge clk_sys_in) begin
    ph_r         <= ~ph_r | ~slow_in;
    src_tick_out <= ph_r | ~slow_in;
    wdt_tick_out <= ph_r | ~slow_in;
  end
endmodule // css_osc_model
`default_nettype wire

// [dv/tb_css_clock_startup.sv]
// testbench for the clock source start-up block
`timescale 1ns/10ps
`default_nettype none
module tb_css_clock_startup;
  localparam int LONG = 40;       // shortened long reset delay
  localparam int K16  = 30;       // shortened 16k start-up count
  // stimulus and observed signals
  logic clk_sys_in = 0, srst_in = 1, slow = 0, fv = 0, wake = 0, conv = 0;
  logic [3:0] cks = 4'h0;
  logic [1:0] startup_time_select = 2'h0;
  logic amp = 1, wr = 0, rdq = 0, src_t, wdt_t, cen, ioen, cvo, aso, fsw, busy, pd;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat, d;
  logic [2:0] cls, rng;
  int n_fail = 0, n_compared = 0, n;
  // free-running system clock
  always #5 clk_sys_in = ~clk_sys_in;
  css_osc_model osc (.clk_sys_in(clk_sys_in), .slow_in(slow), .src_tick_out(src_t),
    .wdt_tick_out(wdt_t));
  css_clock_startup #(.WDT_LONG_CYC(17'(LONG)), .XTAL_16K_CYC(17'(K16)),
    .LFXT_32K_CYC(17'h00032)) uut (
    .clk_sys_in(clk_sys_in), .srst_in(srst_in), .clock_source_select_field_in(cks),
    .startup_time_field_in(startup_time_select), .oscillator_amplifier_option_in(amp), .fuse_valid_in(fv),
    .source_clock_tick_in(src_t), .watchdog_oscillator_tick_in(wdt_t),
    .async_timer_clock_tick_in(src_t), .converter_clock_tick_in(conv), .wake_in(wake),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rdq),
    .reg_rdata_out(rdat), .core_clock_en_out(cen), .io_clock_en_out(ioen),
    .converter_clock_tick_out(cvo), .async_timer_clock_tick_out(aso),
    .amp_full_swing_out(fsw), .source_class_out(cls), .crystal_range_out(rng),
    .startup_busy_out(busy), .power_down_out(pd));
  // single comparison point
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // register write, one strobe cycle
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in) begin wr <= 1; addr <= a; wd <= v; end
    @(posedge clk_sys_in) wr <= 0;
  endtask
  // register read, data in the cycle after the strobe
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_in) begin rdq <= 1; addr <= a; end
    @(posedge clk_sys_in) rdq <= 0;
    #1 v = rdat;
  endtask
  // reset with a fuse image, count cycles until the core is released
  task automatic boot(input logic [3:0] c, input logic [1:0] s, input logic a, input logic v);
    @(posedge clk_sys_in) begin srst_in <= 1; cks <= c; startup_time_select <= s; amp <= a; fv <= v; end
    repeat (8) @(posedge clk_sys_in);
    srst_in <= 0;
    n = 0;
    do begin @(posedge clk_sys_in); #1 n++; end while (busy !== 1'b0 && n < 5000);
  endtask
  // release must come within a few cycles after the longer of the two counts
  task automatic chk_time(input int lo);
    chk("late", 8'(n > lo + 4), 8'h00);
    chk("early", 8'(n < lo), 8'h00);
    chk("core_en", {7'h0, cen}, 8'h01);
  endtask
  // shipped image when no fuse image is valid
  task automatic t_default();
    boot(4'h0, 2'h0, 1'b0, 1'b0);
    chk_time(LONG);
    rreg(8'h02, d);
    chk("fuse", d, 8'h61);
    rreg(8'h03, d);
    chk("decode", d, {2'h2, 3'h0, 3'h4});
    $display("test default done");
  endtask
  // every crystal start-up code and the amplifier option
  task automatic t_xtal();
    int wk[8] = '{258, 258, 1024, 1024, 1024, K16, K16, K16};
    int dl[8] = '{4096, LONG, 0, 4096, LONG, 0, 4096, LONG};
    logic [1:0] ds[8] = '{1, 2, 0, 1, 2, 0, 1, 2};
    for (int i = 0; i < 8; i++) begin
      boot({3'h5 + 3'(i % 3), i[2]}, i[1:0], i[0], 1'b1);
      chk_time(wk[i] > dl[i] ? wk[i] : dl[i]);
      chk("class", {5'h0, cls}, 8'h01);
      chk("range", {5'h0, rng}, i[0] ? 8'h01 + 8'(i % 3) : 8'h04);
      chk("swing", {7'h0, fsw}, {7'h0, ~i[0]});
      rreg(8'h03, d);
      chk("dly", {6'h0, d[7:6]}, {6'h0, ds[i]});
    end
    $display("test crystal done");
  endtask
  // every other source class from the select field
  task automatic t_classes();
    logic [3:0] sel[4] = '{4'h9, 4'h8, 4'h4, 4'h0};
    int lo[4] = '{4096, 18, 6, 6}; // longer of wake count and reset delay
    for (int i = 0; i < 4; i++) begin
      boot(sel[i], 2'h0, 1'b1, 1'b1);
      chk("class", {5'h0, cls}, 8'h02 + 8'(i));
      chk_time(lo[i]);
    end
    $display("test classes done");
  endtask
  // sleep, clock domains, then wake timed on the slow source
  task automatic t_sleep();
    boot(4'hf, 2'h1, 1'b1, 1'b1);
    wreg(8'h00, 8'h03);
    @(posedge clk_sys_in) conv <= 1;
    @(posedge clk_sys_in) conv <= 0;
    #1 chk("conv", {7'h0, cvo}, 8'h01);
    chk("halt", {7'h0, cen}, 8'h00);
    chk("io_halt", {7'h0, ioen}, 8'h01);
    rreg(8'h00, d);
    chk("ctrl", d, 8'h03);
    wreg(8'h00, 8'h06);
    repeat (2) @(posedge clk_sys_in);
    #1 chk("pd", {6'h0, pd, cen}, 8'h02);
    chk("io", {7'h0, ioen}, 8'h00);
    @(posedge clk_sys_in) conv <= 1;
    @(posedge clk_sys_in) conv <= 0;
    #1 chk("conv_sleep", {7'h0, cvo}, 8'h01);
    chk("async", {7'h0, aso}, 8'h01);
    slow <= 1;
    @(posedge clk_sys_in) wake <= 1;
    @(posedge clk_sys_in) wake <= 0;
    n = 0;
    do begin @(posedge clk_sys_in); #1 n++; end while (cen !== 1'b1 && n < 500);
    chk_time(2 * K16 - 2);
    slow <= 0;
    rreg(8'h07, d);
    chk("unmapped", d, 8'h00);
    rreg(8'h01, d);
    chk("status", d, 8'hc2);
    $display("test sleep done");
  endtask
  // verdict
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_in);
    t_default();
    t_xtal();
    t_classes();
    t_sleep();
    complete_run();
  end
  // hang guard: about 50k cycles, well over twice the ~20k the tests need
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end
endmodule // tb_css_clock_startup
`default_nettype wire
